//--- pias_pkg.sv
// Package for the PHY indirect access and status register bank
// Assumes a 16-bit register port with one-cycle read latency on a 10 MHz clock
// How it works
// RULE_01: The five-bit space select field steers every shared-register access to its space.
// RULE_02: Select 11111 reaches the vendor space, indices 0x04D1 and below.
// RULE_03: Select 00011 reaches the MMD3 space.
// RULE_04: Select 00111 reaches the MMD7 space.
// RULE_05: Shared-register accesses with any other select value change nothing at all.
// RULE_06: Software uses only the three supported select values.
// RULE_07: Command 00 reaches the space pointer; other commands reach the pointed data.
// RULE_08: Commands: 00 address, 01 data, 10 increment always, 11 increment on write.
// RULE_09: Cause bits 8..4: sync loss, rx errors, line code, low SNR, energy loss.
// RULE_10: A cause bit latches when its enabled condition drops the link, holds till read.
// RULE_11: Link drop is the OR of every enabled condition; any combination allowed.
// RULE_12: Status bit 14 reads 1 when the pairs are swapped.
// RULE_13: Status bit 13 latches on rx error, cleared by reading the error counter.
// RULE_14: Status bit 12 mirrors the latched inverted-polarity flag of the 10BASE-Te status.
// RULE_15: Polarity flag clears only on a 10BASE-Te status read, not on summary read.
// RULE_16: Reserved bits read as zero and ignore writes.
package pias_pkg;
  localparam int          PIAS_AW              = 5;
  localparam int          PIAS_DW              = 16;
  // Register offsets
  localparam logic [4:0]  PIAS_OFF_CTRL        = 5'h0D;
  localparam logic [4:0]  PIAS_OFF_ADDR_DATA   = 5'h0E;
  localparam logic [4:0]  PIAS_OFF_DROP_CAUSE  = 5'h0F;
  localparam logic [4:0]  PIAS_OFF_SUMMARY     = 5'h10;
  localparam logic [4:0]  PIAS_OFF_RX_ERR_CNT  = 5'h15;
  localparam logic [4:0]  PIAS_OFF_TENBASE     = 5'h1A;
  // Control fields
  localparam int          PIAS_CMD_HI          = 15;
  localparam int          PIAS_CMD_LO          = 14;
  localparam int          PIAS_SEL_HI          = 4;
  localparam logic [4:0]  PIAS_SEL_VENDOR      = 5'h1F;
  localparam logic [4:0]  PIAS_SEL_MMD3        = 5'h03;
  localparam logic [4:0]  PIAS_SEL_MMD7        = 5'h07;
  localparam logic [15:0] PIAS_VENDOR_MAX_IDX  = 16'h04D1;
  localparam logic [15:0] PIAS_ADDR_DATA_RST   = 16'h000A;
  // Drop cause field
  localparam int          PIAS_CAUSE_LO        = 4;
  localparam int          PIAS_NCAUSE          = 5;
  localparam int          PIAS_NEN             = 5;
  // Summary bits
  localparam int          PIAS_SUM_SWAP        = 14;
  localparam int          PIAS_SUM_RXERR       = 13;
  localparam int          PIAS_SUM_POL         = 12;
  localparam int          PIAS_TENBASE_POL     = 4;
  localparam logic [15:0] PIAS_ZERO            = 16'h0000;
  localparam logic [15:0] PIAS_ONE             = 16'h0001;

  typedef enum logic [1:0] {
    PIAS_CMD_ADDR    = 2'b00,
    PIAS_CMD_DATA    = 2'b01,
    PIAS_CMD_INC_RW  = 2'b10,
    PIAS_CMD_INC_WR  = 2'b11
  } pias_cmd_t;

  typedef enum logic [1:0] {
    PIAS_SP_VENDOR = 2'b00,
    PIAS_SP_MMD3   = 2'b01,
    PIAS_SP_MMD7   = 2'b10,
    PIAS_SP_NONE   = 2'b11
  } pias_space_t;
endpackage

//--- pias_mmd_if.sv
`timescale 1ns/100ps
// Interface between the register front end and the extended space port
// Assumes one clock; strobes are one cycle long
interface pias_mmd_if;
  import pias_pkg::*;
  logic              wr;
  logic              rd;
  pias_space_t       space;
  logic [15:0]       index;
  logic [15:0]       wdata;
  logic [15:0]       rdata;
  modport front (output wr, output rd, output space, output index, output wdata, input rdata);
  modport port  (input wr, input rd, input space, input index, input wdata, output rdata);
endinterface

//--- pias_mmd_port.sv
`timescale 1ns/100ps
// Extended space port: forwards one access to the space the front end picked
// Assumes the external space answers a read combinationally in the same cycle
module pias_mmd_port (
  // Front end side
  pias_mmd_if.port          mmd,
  // External extended space
  output logic [1:0]        ext_space,
  output logic [15:0]       ext_index,
  output logic              ext_wr,
  output logic              ext_rd,
  output logic [15:0]       ext_wdata,
  input  wire logic [15:0]  ext_rdata
);
  import pias_pkg::*;

  // Steer the access; unsupported space never strobes
  always_comb begin
    ext_space = mmd.space;                                 // RULE_01
    ext_index = mmd.index;
    ext_wdata = mmd.wdata;
    ext_wr    = mmd.wr && (mmd.space != PIAS_SP_NONE);     // RULE_05
    ext_rd    = mmd.rd && (mmd.space != PIAS_SP_NONE);     // RULE_05
    mmd.rdata = (mmd.space != PIAS_SP_NONE) ? ext_rdata : PIAS_ZERO;
  end
endmodule

//--- pias_regs.sv
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
// Indirect access control, shared address/data, drop cause and status summary
// Assumes synchronous register port, PHY status events on clk, reads one cycle late
module pias_regs
  import pias_pkg::*;
#(
  parameter int DW = pias_pkg::PIAS_DW
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rstn,
  // Register port
  input  wire logic [pias_pkg::PIAS_AW-1:0]  reg_addr,
  input  wire logic [DW-1:0]                 reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic [DW-1:0]                      reg_rdata,
  // Fast drop conditions and their enables
  input  wire logic [pias_pkg::PIAS_NEN-1:0] drop_enable,
  input  wire logic [pias_pkg::PIAS_NEN-1:0] drop_condition,
  output logic                               link_drop,
  // PHY status events
  input  wire logic                          pairs_swapped,
  input  wire logic                          rx_error_event,
  input  wire logic                          polarity_inverted_event,
  // External extended space
  output logic [1:0]                         ext_space,
  output logic [15:0]                        ext_index,
  output logic                               ext_wr,
  output logic                               ext_rd,
  output logic [15:0]                        ext_wdata,
  input  wire logic [15:0]                   ext_rdata
);
  import pias_pkg::*;

  // Elaboration check: the logic serves only the 16-bit register width
  if (DW != PIAS_DW) begin : g_dw_check
    $error("pias_regs: data width must be 16");
  end

  typedef struct packed {
    logic [1:0]              cmd;
    logic [4:0]              sel;
    logic [15:0]             ptr_vendor;
    logic [15:0]             ptr_mmd3;
    logic [15:0]             ptr_mmd7;
    logic [15:0]             addr_data;
    logic [PIAS_NCAUSE-1:0]  cause;
    logic                    rx_err_latch;
    logic                    pol_latch;
    logic [15:0]             rdata;
  } pias_state_t;

  pias_state_t q, d;
  pias_mmd_if  mmd ();

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the space select field
  function automatic pias_space_t pias_decode(input logic [4:0] sel);
    case (sel)
      PIAS_SEL_VENDOR: pias_decode = PIAS_SP_VENDOR;       // RULE_02
      PIAS_SEL_MMD3:   pias_decode = PIAS_SP_MMD3;         // RULE_03
      PIAS_SEL_MMD7:   pias_decode = PIAS_SP_MMD7;         // RULE_04
      default:         pias_decode = PIAS_SP_NONE;         // RULE_05
    endcase
  endfunction

  // Pointer of the chosen space
  function automatic logic [15:0] pias_ptr(input pias_state_t s, input pias_space_t sp);
    case (sp)
      PIAS_SP_VENDOR: pias_ptr = s.ptr_vendor;
      PIAS_SP_MMD3:   pias_ptr = s.ptr_mmd3;
      PIAS_SP_MMD7:   pias_ptr = s.ptr_mmd7;
      default:        pias_ptr = PIAS_ZERO;
    endcase
  endfunction

  pias_space_t space;
  logic        is_data;
  logic        sh_wr;
  logic        sh_rd;
  logic        vendor_ok;
  logic [15:0] cur_ptr;
  logic        inc;
  logic [PIAS_NCAUSE-1:0] drop_hits;

  ////////////////////////////////////////////////////////////////////////////
  // Shared register access qualifiers
  always_comb begin
    space     = pias_decode(q.sel);                                     // RULE_01
    is_data   = (q.cmd != PIAS_CMD_ADDR);                               // RULE_07
    cur_ptr   = pias_ptr(q, space);
    vendor_ok = (space != PIAS_SP_VENDOR) || (cur_ptr <= PIAS_VENDOR_MAX_IDX); // RULE_02
    sh_wr     = reg_wr && (reg_addr == PIAS_OFF_ADDR_DATA) && (space != PIAS_SP_NONE);
    sh_rd     = reg_rd && (reg_addr == PIAS_OFF_ADDR_DATA) && (space != PIAS_SP_NONE);
    case (q.cmd)
      PIAS_CMD_INC_RW: inc = sh_wr || sh_rd;                            // RULE_08
      PIAS_CMD_INC_WR: inc = sh_wr;                                     // RULE_08
      default:         inc = 1'b0;
    endcase
    inc = inc && is_data;
  end

  // Extended space connection
  always_comb begin
    mmd.wr    = sh_wr && is_data && vendor_ok;
    mmd.rd    = sh_rd && is_data && vendor_ok;
    mmd.space = space;
    mmd.index = cur_ptr;
    mmd.wdata = reg_wdata;
  end

  pias_mmd_port u_port (
    .mmd       (mmd.port),
    .ext_space (ext_space),
    .ext_index (ext_index),
    .ext_wr    (ext_wr),
    .ext_rd    (ext_rd),
    .ext_wdata (ext_wdata),
    .ext_rdata (ext_rdata)
  );

  // Fast drop: OR of every enabled condition
  always_comb begin
    drop_hits = drop_enable & drop_condition;                           // RULE_11
    link_drop = |drop_hits;                                             // RULE_11
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    d = q;
    // Control register: command and select, middle bits reserved
    if (reg_wr && (reg_addr == PIAS_OFF_CTRL)) begin
      d.cmd = reg_wdata[PIAS_CMD_HI:PIAS_CMD_LO];                       // RULE_16
      d.sel = reg_wdata[PIAS_SEL_HI:0];
    end
    // Shared register write: pointer or data
    if (sh_wr && !is_data) begin
      case (space)                                                      // RULE_07
        PIAS_SP_VENDOR: d.ptr_vendor = reg_wdata;
        PIAS_SP_MMD3:   d.ptr_mmd3   = reg_wdata;
        PIAS_SP_MMD7:   d.ptr_mmd7   = reg_wdata;
        default:        d.ptr_mmd7   = q.ptr_mmd7;
      endcase
      d.addr_data = reg_wdata;
    end else if (sh_wr) begin
      d.addr_data = reg_wdata;
    end
    // Post increment of the active pointer
    if (inc) begin
      case (space)                                                      // RULE_08
        PIAS_SP_VENDOR: d.ptr_vendor = q.ptr_vendor + PIAS_ONE;
        PIAS_SP_MMD3:   d.ptr_mmd3   = q.ptr_mmd3 + PIAS_ONE;
        PIAS_SP_MMD7:   d.ptr_mmd7   = q.ptr_mmd7 + PIAS_ONE;
        default:        d.ptr_mmd7   = q.ptr_mmd7;
      endcase
    end
    // Cause bits latch on a drop; cleared by reading, new cause wins
    if (reg_rd && (reg_addr == PIAS_OFF_DROP_CAUSE)) begin
      d.cause = '0;
    end
    d.cause = d.cause | drop_hits;                                      // RULE_10
    // Rx error latch: cleared by a counter read, event wins
    if (reg_rd && (reg_addr == PIAS_OFF_RX_ERR_CNT)) begin
      d.rx_err_latch = 1'b0;                                            // RULE_13
    end
    if (rx_error_event) begin
      d.rx_err_latch = 1'b1;                                            // RULE_13
    end
    // Polarity latch: only a 10BASE-Te status read clears it
    if (reg_rd && (reg_addr == PIAS_OFF_TENBASE)) begin
      d.pol_latch = 1'b0;                                               // RULE_15
    end
    if (polarity_inverted_event) begin
      d.pol_latch = 1'b1;                                               // RULE_14
    end
    // Read data, valid the cycle after the strobe
    d.rdata = PIAS_ZERO;
    if (reg_rd) begin
      case (reg_addr)
        PIAS_OFF_CTRL: begin
          d.rdata[PIAS_CMD_HI:PIAS_CMD_LO] = q.cmd;                     // RULE_16
          d.rdata[PIAS_SEL_HI:0]           = q.sel;
        end
        PIAS_OFF_ADDR_DATA: begin
          if (space == PIAS_SP_NONE) begin
            d.rdata = q.addr_data;                                      // RULE_05
          end else if (!is_data) begin
            d.rdata = cur_ptr;                                          // RULE_07
          end else if (vendor_ok) begin
            d.rdata = mmd.rdata;                                        // RULE_07
          end else begin
            d.rdata = PIAS_ZERO;
          end
        end
        PIAS_OFF_DROP_CAUSE: begin
          d.rdata[PIAS_CAUSE_LO +: PIAS_NCAUSE] = q.cause;              // RULE_09
        end
        PIAS_OFF_SUMMARY: begin
          d.rdata[PIAS_SUM_SWAP]  = pairs_swapped;                      // RULE_12
          d.rdata[PIAS_SUM_RXERR] = q.rx_err_latch;                     // RULE_13
          d.rdata[PIAS_SUM_POL]   = q.pol_latch;                        // RULE_14
        end
        PIAS_OFF_TENBASE: begin
          d.rdata[PIAS_TENBASE_POL] = q.pol_latch;                      // RULE_15
        end
        default: begin
          d.rdata = PIAS_ZERO;                                          // RULE_16
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      q.cmd          <= PIAS_CMD_ADDR;
      q.sel          <= 5'h00;
      q.ptr_vendor   <= PIAS_ZERO;
      q.ptr_mmd3     <= PIAS_ZERO;
      q.ptr_mmd7     <= PIAS_ZERO;
      q.addr_data    <= PIAS_ADDR_DATA_RST;
      q.cause        <= '0;
      q.rx_err_latch <= 1'b0;
      q.pol_latch    <= 1'b0;
      q.rdata        <= PIAS_ZERO;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
endmodule

//--- pias_regs_chk.sv
`timescale 1ns/100ps
// Checker for the indirect access and status register bank
// Assumes it is bound to pias_regs and sees only its ports
module pias_regs_chk
  import pias_pkg::*;
#(
  parameter int DW = pias_pkg::PIAS_DW
) (
  // Clock and reset
  input wire logic                          clk,
  input wire logic                          rstn,
  // Register port
  input wire logic [pias_pkg::PIAS_AW-1:0]  reg_addr,
  input wire logic [DW-1:0]                 reg_wdata,
  input wire logic                          reg_wr,
  input wire logic                          reg_rd,
  input wire logic [DW-1:0]                 reg_rdata,
  // Fast drop
  input wire logic [pias_pkg::PIAS_NEN-1:0] drop_enable,
  input wire logic [pias_pkg::PIAS_NEN-1:0] drop_condition,
  input wire logic                          link_drop,
  // Status events
  input wire logic                          pairs_swapped,
  input wire logic                          rx_error_event,
  input wire logic                          polarity_inverted_event,
  // Extended space
  input wire logic [1:0]                    ext_space,
  input wire logic [15:0]                   ext_index,
  input wire logic                          ext_wr,
  input wire logic                          ext_rd,
  input wire logic [15:0]                   ext_wdata,
  input wire logic [15:0]                   ext_rdata
);
  import pias_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  // Read decodes
  logic rd_sum;
  logic rd_ten;
  logic rd_cause;
  assign rd_sum   = reg_rd && reg_addr == PIAS_OFF_SUMMARY;
  assign rd_ten   = reg_rd && reg_addr == PIAS_OFF_TENBASE;
  assign rd_cause = reg_rd && reg_addr == PIAS_OFF_DROP_CAUSE;
  // Event followed by a summary or cause read, no clearing read between
  sequence rx_err_s; rx_error_event ##1 !reg_rd ##1 rd_sum; endsequence
  sequence pol_s; polarity_inverted_event ##1 !reg_rd ##1 rd_sum ##1 !rd_ten ##1 rd_sum; endsequence
  sequence sync_drop_s; (drop_enable[4] && drop_condition[4]) ##1 !reg_rd ##1 rd_cause; endsequence
  ////////////////////////////////////////////////////////////////////////////
  link_drop_or_a: assert property (link_drop == |(drop_enable & drop_condition))
    else $error("link drop differs from enabled conditions");
  ext_wr_cause_a: assert property (ext_wr |-> reg_wr && reg_addr == PIAS_OFF_ADDR_DATA && ext_wdata == reg_wdata)
    else $error("extended write without shared register write");
  ext_rd_data_a: assert property (ext_rd |=> reg_rdata == $past(ext_rdata))
    else $error("extended read data not returned");
  no_space_quiet_a: assert property (ext_space == PIAS_SP_NONE |-> !ext_wr && !ext_rd)
    else $error("strobe toward unsupported space");
  vendor_limit_a: assert property (ext_space == PIAS_SP_VENDOR && ext_index > PIAS_VENDOR_MAX_IDX |-> !ext_rd && !ext_wr)
    else $error("vendor access beyond last index");
  swap_bit_a: assert property (rd_sum |=> reg_rdata[14] == $past(pairs_swapped))
    else $error("swap bit wrong");
  rx_latch_a: assert property (rx_err_s |=> reg_rdata[13])
    else $error("receive error latch lost");
  pol_hold_a: assert property (pol_s |=> reg_rdata[12])
    else $error("polarity cleared by summary read");
  sync_cause_a: assert property (sync_drop_s |=> reg_rdata[8])
    else $error("sync loss cause not latched");
  cause_rsvd_a: assert property (rd_cause |=> reg_rdata[15:9] == 7'h00 && reg_rdata[3:0] == 4'h0)
    else $error("cause reserved bits not zero");
endmodule

bind pias_regs pias_regs_chk #(.DW(DW)) chk_u (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .drop_enable(drop_enable), .drop_condition(drop_condition),
  .link_drop(link_drop), .pairs_swapped(pairs_swapped), .rx_error_event(rx_error_event),
  .polarity_inverted_event(polarity_inverted_event), .ext_space(ext_space), .ext_index(ext_index), .ext_wr(ext_wr),
  .ext_rd(ext_rd), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata));

//--- pias_regs_tb.sv
`timescale 1ns/100ps
// Testbench for the indirect access and status register bank
// Assumes a 10 MHz clock and a synchronous active-low reset
module pias_regs_tb;
  import pias_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, link_drop, ext_wr, ext_rd;
  logic        pairs_swapped = 1'b0, rx_error_event = 1'b0, polarity_inverted_event = 1'b0;
  logic [4:0]  reg_addr = 5'h00, drop_enable = 5'h00, drop_condition = 5'h00, sel;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, ext_index, ext_wdata, ext_rdata, ptr, exp_ptr, seen_index;
  logic [1:0]  ext_space, seen_space;
  logic [15:0] seen_wdata;
  int          fail_count = 0, checks = 0;
  // Extended space answers with the inverted index
  assign ext_rdata = ~ext_index;
  always #50 clk = ~clk;
  pias_regs dut_u (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .drop_enable(drop_enable), .drop_condition(drop_condition),
    .link_drop(link_drop), .pairs_swapped(pairs_swapped), .rx_error_event(rx_error_event),
    .polarity_inverted_event(polarity_inverted_event), .ext_space(ext_space), .ext_index(ext_index),
    .ext_wr(ext_wr), .ext_rd(ext_rd), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata));
  // Capture where the last extended strobe went
  always @(negedge clk) begin
    if (ext_wr || ext_rd) begin
      seen_space = ext_space;
      seen_index = ext_index;
      seen_wdata = ext_wdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read, mask and compare the data of the following cycle
  task automatic rd(input logic [4:0] a, input logic [15:0] mask, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    cmp($sformatf("reg %h", a), exp, reg_rdata & mask);
  endtask
  task automatic final_report;
    $display("Checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rd(PIAS_OFF_ADDR_DATA, 16'hFFFF, PIAS_ADDR_DATA_RST);
    rd(5'h03, 16'hFFFF, 16'h0000);
    wr(PIAS_OFF_CTRL, 16'h0005);
    wr(PIAS_OFF_ADDR_DATA, 16'h1234);
    rd(PIAS_OFF_ADDR_DATA, 16'hFFFF, PIAS_ADDR_DATA_RST);
    wr(PIAS_OFF_CTRL, 16'hFFFF);
    rd(PIAS_OFF_CTRL, 16'hFFFF, 16'hC01F);
    // Every space with every data command
    for (int s = 0; s < 3; s++) begin
      sel = (s == 0) ? PIAS_SEL_VENDOR : (s == 1) ? PIAS_SEL_MMD3 : PIAS_SEL_MMD7;
      ptr = 16'h04D0 - 16'(s) * 16'h0100;
      for (int c = 1; c < 4; c++) begin
        wr(PIAS_OFF_CTRL, {11'h000, sel});
        wr(PIAS_OFF_ADDR_DATA, ptr);
        wr(PIAS_OFF_CTRL, {2'(c), 9'h000, sel});
        seen_index = 16'hFFFF;
        seen_wdata = 16'h0000;
        wr(PIAS_OFF_ADDR_DATA, 16'h5A5A);
        cmp("write index", ptr, seen_index);
        cmp("write data", 16'h5A5A, seen_wdata);
        cmp("write space", 16'(s), {14'h0000, seen_space});
        exp_ptr = ptr + ((c != 1) ? 16'h0001 : 16'h0000);
        rd(PIAS_OFF_ADDR_DATA, 16'hFFFF, ~exp_ptr);
        exp_ptr = exp_ptr + ((c == 2) ? 16'h0001 : 16'h0000);
        wr(PIAS_OFF_CTRL, {11'h000, sel});
        rd(PIAS_OFF_ADDR_DATA, 16'hFFFF, exp_ptr);
      end
    end
    // Vendor data beyond the last index: pointer set in vendor address mode first
    wr(PIAS_OFF_CTRL, 16'h001F);
    wr(PIAS_OFF_ADDR_DATA, 16'h04D2);
    wr(PIAS_OFF_CTRL, 16'h801F);
    rd(PIAS_OFF_ADDR_DATA, 16'hFFFF, 16'h0000);
    wr(PIAS_OFF_CTRL, 16'h001F);
    rd(PIAS_OFF_ADDR_DATA, 16'hFFFF, 16'h04D3);
    // Each cause alone with all conditions asserted, then a mix of two conditions with every cause enabled
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      drop_enable <= (i < 5) ? 5'(1 << i) : 5'h1F;
      drop_condition <= (i < 5) ? 5'h1F : 5'h05;
      @(negedge clk);
      cmp("link drop", 16'h0001, {15'h0000, link_drop});
      @(posedge clk);
      drop_condition <= 5'h00;
      rd(PIAS_OFF_DROP_CAUSE, 16'hFFFF, (i < 5) ? 16'(1 << (i + 4)) : 16'h0050);
      rd(PIAS_OFF_DROP_CAUSE, 16'hFFFF, 16'h0000);
    end
    // No condition present: the link stays up
    @(negedge clk);
    cmp("link drop idle", 16'h0000, {15'h0000, link_drop});
    // Summary bits
    @(posedge clk);
    pairs_swapped <= 1'b1;
    rx_error_event <= 1'b1;
    @(posedge clk);
    rx_error_event <= 1'b0;
    rd(PIAS_OFF_SUMMARY, 16'h7000, 16'h6000);
    rd(PIAS_OFF_SUMMARY, 16'h7000, 16'h6000);
    rd(PIAS_OFF_RX_ERR_CNT, 16'hFFFF, 16'h0000);
    rd(PIAS_OFF_SUMMARY, 16'h7000, 16'h4000);
    @(posedge clk);
    polarity_inverted_event <= 1'b1;
    @(posedge clk);
    polarity_inverted_event <= 1'b0;
    rd(PIAS_OFF_SUMMARY, 16'h7000, 16'h5000);
    rd(PIAS_OFF_SUMMARY, 16'h7000, 16'h5000);
    rd(PIAS_OFF_TENBASE, 16'h0010, 16'h0010);
    rd(PIAS_OFF_SUMMARY, 16'h7000, 16'h4000);
    final_report;
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #(3000 * 100);
    fail_count++;
    $display("Error watchdog expected finish seen timeout");
    final_report;
  end
endmodule
